// [test/m11c_board.sv]
// Board-side driver of the counter control pins
`timescale 1ns/1ps
module m11c_board (
  input wire logic i_clk,
  input wire logic i_clear,
  input wire logic i_up,
  input wire logic i_hold,
  input wire logic i_oe,
  output logic o_clear_n,
  output logic o_up,
  output logic o_hold,
  output logic o_oe_n
);
  // Pins change just after an edge, as board flops would
  always @(posedge i_clk) begin
    o_clear_n <= ~i_clear;
    o_up <= i_up;
    o_hold <= i_hold;
  end
  // Enable reaches the pin with no clock in its path
  assign o_oe_n = ~i_oe;
endmodule

// [test/test_m11c_counter.sv]
// Self-checking bench for the modulo-eleven counter
`timescale 1ns/1ps
module test_m11c_counter;
  import m11c_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic clr = 1'b0, up = 1'b0, hld = 1'b1, oe = 1'b1;
  logic clear_n, up_pin, hold_pin, oe_n;
  logic [COUNT_W-1:0] cnt, cnt_oe, e;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [DATA_W-1:0] wdata = 32'h0, rdata, wd;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_count = 0;
  int checked = 0;
  int seed = 32'h4CA1;

  always #10 i_clk = ~i_clk;

  m11c_board u_m11c_board (.i_clk(i_clk), .i_clear(clr), .i_up(up),
    .i_hold(hld), .i_oe(oe), .o_clear_n(clear_n), .o_up(up_pin),
    .o_hold(hold_pin), .o_oe_n(oe_n));

  m11c_counter u_m11c_counter (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_clear_n(clear_n), .i_up(up_pin), .i_hold(hold_pin), .i_oe_n(oe_n),
    .o_count_out(cnt), .o_count_oe(cnt_oe), .i_awaddr(awaddr),
    .i_awprot(3'h0), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arprot(3'h0), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready));

  task automatic fail(input string m);
    err_count++;
    $display("ERROR %0t %s", $time, m);
  endtask

  task automatic chk(input logic [COUNT_W-1:0] x);
    @(negedge i_clk);
    checked++;
    if (cnt !== x) fail("count mismatch");
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [3:0] s,
      input logic [1:0] r);
    logic ta, tw, tb;
    bq.push_back(r);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      @(posedge i_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [1:0] r);
    logic ta, tr;
    rq.push_back({r, d});
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = arvalid && arready;
      tr = rvalid;
      @(posedge i_clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask

  // Results are judged where they appear, against the oldest note
  always @(negedge i_clk) begin
    if (bvalid && bready) begin
      checked++;
      if (bq.size() == 0 || bresp !== bq.pop_front()) fail("write resp");
    end
    if (rvalid && rready) begin
      checked++;
      if (rq.size() == 0 || {rresp, rdata} !== rq.pop_front())
        fail("read data");
    end
  end

  // Start from zero under hold, then release and follow the sequence
  task automatic run(input logic d);
    int n;
    @(posedge i_clk);
    hld <= 1'b1;
    up <= d;
    repeat (8) @(negedge i_clk);
    wr(CTRL_OFFSET, 32'h0000_0002, 4'hF, RESP_OKAY);
    chk(COUNT_MIN);
    @(posedge i_clk);
    hld <= 1'b0;
    n = 0;
    while (cnt === COUNT_MIN && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    e = d ? COUNT_STEP : COUNT_MAX;
    checked++;
    if (cnt !== e) fail("first step");
    repeat (11) begin
      if (d) e = (e == COUNT_MAX) ? COUNT_MIN : e + COUNT_STEP;
      else e = (e == COUNT_MIN) ? COUNT_MAX : e - COUNT_STEP;
      chk(e);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(20 * 5000);
    fail("timeout");
    close_out;
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(CTRL_OFFSET, DATA_ZERO, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      @(posedge i_clk);
      oe <= i[0];
      @(negedge i_clk);
      checked++;
      if (cnt_oe !== {COUNT_W{i[0]}}) fail("enable");
    end
    // Clear must win over hold; hold then keeps zero
    @(posedge i_clk);
    up <= 1'b1;
    clr <= 1'b1;
    repeat (8) @(negedge i_clk);
    chk(COUNT_MIN);
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (8) @(negedge i_clk);
    repeat (6) chk(COUNT_MIN);
    rd(STATUS_OFFSET, 32'h0000_00B0, RESP_OKAY);
    run(1'b1);
    // Clear while counting up
    @(posedge i_clk);
    clr <= 1'b1;
    repeat (8) @(negedge i_clk);
    repeat (4) chk(COUNT_MIN);
    rd(STATUS_OFFSET, 32'h0000_00D0, RESP_OKAY);
    // Drivers off for the down run: the count must keep stepping
    @(posedge i_clk);
    clr <= 1'b0;
    oe <= 1'b0;
    run(1'b0);
    wr(8'h10, $random(seed), 4'hF, RESP_SLVERR);
    rd(8'h10, DATA_ZERO, RESP_SLVERR);
    wd = $random(seed) & 32'hFFFF_FFFD;
    wr(CTRL_OFFSET, wd, 4'hF, RESP_OKAY);
    rd(CTRL_OFFSET, wd & 32'h0000_0001, RESP_OKAY);
    wr(CTRL_OFFSET, ~wd & 32'h0000_0001, 4'h0, RESP_OKAY);
    rd(CTRL_OFFSET, wd & 32'h0000_0001, RESP_OKAY);
    close_out;
  end
endmodule

// [verilog/m11c_counter.sv]
// Modulo-eleven up/down counter with AXI4-Lite control and status
// How it works
// - A low clear forces the count to zero at the fifth clock edge after the pin falls.
// - The count runs through eleven values, zero to ten, and wraps.
// - Counting down steps lower each clock and wraps zero to ten.
// - Counting up steps higher each clock and wraps ten to zero.
// - Hold keeps the count still while clear is inactive.
// - The direction input picks up or down on each enabled clock.
// - Output enable gates the count drivers without a clock edge.
// - Clear and output enable are both asserted by a low level.
// - The four output bits are the count value in plain binary.
`timescale 1ns/1ps
module m11c_counter
  import m11c_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clear_n,
  input wire logic i_up,
  input wire logic i_hold,
  input wire logic i_oe_n,
  output logic [m11c_pkg::COUNT_W-1:0] o_count_out,
  output logic [m11c_pkg::COUNT_W-1:0] o_count_oe,
  input wire logic [m11c_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [m11c_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [m11c_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [m11c_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);

  function automatic logic [COUNT_W-1:0] step_count(
    input logic [COUNT_W-1:0] cur,
    input logic up
  );
    logic [COUNT_W-1:0] res;
    if (up) begin
      res = (cur >= COUNT_MAX) ? COUNT_MIN : cur + COUNT_STEP;
    end else begin
      res = (cur == COUNT_MIN) ? COUNT_MAX : cur - COUNT_STEP;
    end
    return res;
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    return (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET);
  endfunction

  // Pin synchronisation
  logic [PIN_W-1:0] pin_async;
  logic [PIN_W-1:0] pin_level;

  assign pin_async[PIN_CLEAR] = i_clear_n;
  assign pin_async[PIN_UP] = i_up;
  assign pin_async[PIN_HOLD] = i_hold;

  m11c_sync3 u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(pin_async),
    .o_level(pin_level)
  );

  // Effective controls: clear and hold pins merged with the software overrides
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic sw_clear_reg;
  logic sw_clear_next;
  logic clear_eff;
  logic hold_eff;
  logic up_eff;

  assign clear_eff = !pin_level[PIN_CLEAR] || sw_clear_reg;
  assign hold_eff = pin_level[PIN_HOLD] || ctrl_reg[CTRL_HOLD_BIT];
  assign up_eff = pin_level[PIN_UP];

  // Counter
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;

  always_comb begin
    if (clear_eff) begin
      count_next = COUNT_MIN;
    end else if (hold_eff) begin
      count_next = count_reg;
    end else begin
      count_next = step_count(count_reg, up_eff);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // The count bits are the register itself; enables bypass the clock
  assign o_count_out = count_reg;
  assign o_count_oe = {COUNT_W{!i_oe_n}};

  // Write channel
  logic aw_have_reg;
  logic aw_have_next;
  logic w_have_reg;
  logic w_have_next;
  logic [ADDR_W-1:0] waddr_reg;
  logic [ADDR_W-1:0] waddr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic do_write;

  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    sw_clear_next = 1'b0;
    if (i_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      waddr_next = i_awaddr;
    end
    if (i_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next = i_wdata;
      wstrb_next = i_wstrb;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = reg_hit(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
      // Only the low byte lane carries control bits
      if (waddr_reg == CTRL_OFFSET && wstrb_reg[0]) begin
        ctrl_next[CTRL_HOLD_BIT] = wdata_reg[CTRL_HOLD_BIT];
        sw_clear_next = wdata_reg[CTRL_CLEAR_BIT];
      end
    end
    if (bvalid_reg && i_bready) begin
      bvalid_next = 1'b0;
    end
    // New transfers wait until the response is gone
    awready_next = !aw_have_next && !bvalid_next;
    wready_next = !w_have_next && !bvalid_next;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= CTRL_OFFSET;
      wdata_reg <= DATA_ZERO;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
      sw_clear_reg <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      ctrl_reg <= ctrl_next;
      sw_clear_reg <= sw_clear_next;
    end
  end

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;

  // Read channel
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic [DATA_W-1:0] status_word;

  always_comb begin
    status_word = DATA_ZERO;
    status_word[STAT_COUNT_LSB +: COUNT_W] = count_reg;
    status_word[STAT_UP_BIT] = up_eff;
    status_word[STAT_HOLD_BIT] = hold_eff;
    status_word[STAT_CLEAR_BIT] = clear_eff;
    status_word[STAT_OE_BIT] = !i_oe_n;
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && i_rready) begin
      rvalid_next = 1'b0;
    end
    if (i_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = DATA_ZERO;
      if (i_araddr == CTRL_OFFSET) begin
        rdata_next[CTRL_HOLD_BIT] = ctrl_reg[CTRL_HOLD_BIT];
      end else if (i_araddr == STATUS_OFFSET) begin
        rdata_next = status_word;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= DATA_ZERO;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  // Checks on the counting behaviour and the write response
  a_clear_zero: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    clear_eff |=> (count_reg == COUNT_MIN)
  ) else $error("count not zero after clear");

  a_count_range: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    count_reg <= COUNT_MAX
  ) else $error("count left the eleven-state range");

  a_down_step: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!clear_eff && !hold_eff && !up_eff && count_reg != COUNT_MIN)
      |=> (count_reg == $past(count_reg) - COUNT_STEP)
  ) else $error("down count did not step lower");

  a_down_wrap: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!clear_eff && !hold_eff && !up_eff && count_reg == COUNT_MIN)
      |=> (count_reg == COUNT_MAX)
  ) else $error("down count did not wrap to ten");

  a_up_step: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!clear_eff && !hold_eff && up_eff && count_reg != COUNT_MAX)
      |=> (count_reg == $past(count_reg) + COUNT_STEP)
  ) else $error("up count did not step higher");

  a_up_wrap: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!clear_eff && !hold_eff && up_eff && count_reg == COUNT_MAX)
      |=> (count_reg == COUNT_MIN)
  ) else $error("up count did not wrap to zero");

  a_hold_keep: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!clear_eff && hold_eff) |=> $stable(count_reg)
  ) else $error("count moved during hold");

  a_pin_clear: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!pin_level[PIN_CLEAR] && !hold_eff) ##1 !pin_level[PIN_CLEAR]
      |-> (count_reg == COUNT_MIN)
  ) else $error("low clear pin did not hold count at zero");

  a_oe_follow: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!clear_eff && !hold_eff && i_oe_n) |=> (count_reg != $past(count_reg))
  ) else $error("count stalled while drivers were off");

  a_write_resp: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    do_write |=> (o_bvalid && !o_awready && !o_wready)
  ) else $error("write response missing");

endmodule

// [verilog/m11c_pkg.sv]
// Constants shared by the modulo-eleven counter and its register slave
package m11c_pkg;

  localparam int COUNT_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PIN_W = 3;

  // Count limits: eleven states, values zero to ten
  localparam logic [COUNT_W-1:0] COUNT_MIN = 4'h0;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 4'hA;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 4'h1;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

  // Control register fields
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_UP_BIT = 4;
  localparam int STAT_HOLD_BIT = 5;
  localparam int STAT_CLEAR_BIT = 6;
  localparam int STAT_OE_BIT = 7;

  // Filtered pin order in the synchroniser bus
  localparam int PIN_CLEAR = 0;
  localparam int PIN_UP = 1;
  localparam int PIN_HOLD = 2;
  // Inactive pin levels: clear_n high, down, not holding
  localparam logic [PIN_W-1:0] PIN_RESET = 3'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage

// [verilog/m11c_sync3.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module m11c_sync3
  import m11c_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [m11c_pkg::PIN_W-1:0] i_async,
  output logic [m11c_pkg::PIN_W-1:0] o_level
);

  logic [PIN_W-1:0] s1_reg;
  logic [PIN_W-1:0] s2_reg;
  logic [PIN_W-1:0] s3_reg;
  logic [PIN_W-1:0] level_reg;
  logic [PIN_W-1:0] level_next;

  // Per bit: only a level seen on two settled stages is accepted
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_reg <= PIN_RESET;
      s2_reg <= PIN_RESET;
      s3_reg <= PIN_RESET;
      level_reg <= PIN_RESET;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign o_level = level_reg;

endmodule
